// File: src/wdt_pkg.sv
// Package with register map, field layout and types of the watchdog.
package wdt_pkg;
    localparam int             WDT_AW      = 8;
    localparam logic [7:0]     OFF_RELOAD  = 8'h00;
    localparam logic [7:0]     OFF_VALUE   = 8'h04;
    localparam logic [7:0]     OFF_CTRL    = 8'h08;
    localparam logic [7:0]     OFF_ICLR    = 8'h0c;
    localparam logic [7:0]     OFF_STAT    = 8'h10;
    localparam logic [7:0]     OFF_LOCK    = 8'h14;
    localparam int             CTL_EN      = 0;
    localparam int             CTL_RSTEN   = 1;
    localparam int             CTL_STALL   = 2;
    localparam int             CTL_MSEL    = 3;
    localparam int             STAT_INT    = 0;
    localparam int             LOCK_BIT    = 0;
    localparam logic [31:0]    RELOAD_RST  = 32'hffffffff;
    localparam logic [31:0]    COUNT_ZERO  = 32'h00000000;
    localparam logic [31:0]    COUNT_ONE   = 32'h00000001;
    // Unlock key, value is arbitrary
    localparam logic [31:0]    UNLOCK_KEY  = 32'h5a17c30e;

    typedef struct packed {
        logic              sel;
        logic              enable;
        logic              write;
        logic [7:0]        addr;
        logic [31:0]       wdata;
    } wdt_apb_req_t;

    typedef enum logic [1:0] {
        WDT_IDLE = 2'b00,
        WDT_RUN  = 2'b01,
        WDT_PEND = 2'b10,
        WDT_BITE = 2'b11
    } wdt_state_t;
endpackage

// File: src/wdt_sync.sv
// Two-flop synchroniser for an asynchronous level.
`timescale 1ns/100ps
module wdt_sync (
    input  wire logic sys_clk,
    input  wire logic rst,
    input  wire logic asyncIn,
    output logic      syncOut
);
    logic stage1;

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            stage1  <= 1'b0;
            syncOut <= 1'b0;
        end else begin
            stage1  <= asyncIn;
            syncOut <= stage1;
        end
    end
endmodule

// File: src/wdt_apb_if.sv
// APB slave handshake: one wait-free access, registered answers.
`timescale 1ns/100ps
module wdt_apb_if
    import wdt_pkg::*;
(
    input  wire logic          sys_clk,
    input  wire logic          rst,
    input  wire wdt_apb_req_t  req,
    input  wire logic [31:0]   rdData,
    input  wire logic          addrOk,
    output logic               pready,
    output logic               pslverr,
    output logic [31:0]        prdata,
    output logic               wrStb
);
    logic setup;

    assign setup = req.sel && !req.enable;
    assign wrStb = req.sel && req.enable && pready && req.write && addrOk;

    // Answer is prepared in setup so that access ends in one cycle
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= COUNT_ZERO;
        end else begin
            pready  <= setup;
            pslverr <= setup && !addrOk;
            if (setup && !req.write && addrOk) begin
                prdata <= rdData;
            end else if (setup) begin
                prdata <= COUNT_ZERO;
            end
        end
    end
endmodule

// File: src/wdt_top.sv
// Two-stage watchdog timer with APB register access.
//
// The APB slave port and the address map were left to the implementer.
`timescale 1ns/100ps
module wdt_top
    import wdt_pkg::*;
(
    input  wire logic               sys_clk,
    input  wire logic               rst,
    input  wire logic               psel,
    input  wire logic               penable,
    input  wire logic               pwrite,
    input  wire logic [WDT_AW-1:0]  paddr,
    input  wire logic [31:0]        pwdata,
    input  wire logic               debugHalt,
    output logic                    pready,
    output logic                    pslverr,
    output logic [31:0]             prdata,
    output logic                    irq,
    output logic                    sysReset
);
    wdt_apb_req_t req;
    wdt_state_t   state;
    wdt_state_t   next_state;
    logic [31:0]  reloadValue;
    logic [31:0]  count;
    logic [31:0]  rdData;
    logic         ctrlEn;
    logic         rstEn;
    logic         stallEn;
    logic         maskedStatusSelect;
    logic         locked;
    logic         haltSync;
    logic         wrStb;
    logic         addrOk;
    logic         cfgWr;
    logic         ldWr;
    logic         ctlWr;
    logic         clrWr;
    logic         lockWr;
    logic         tick;
    logic         timeout;
    logic         rawInt;
    logic         next_raw;

    assign req = '{sel:    psel,
                   enable: penable,
                   write:  pwrite,
                   addr:   paddr,
                   wdata:  pwdata};

    wdt_apb_if u_apb (
        .sys_clk (sys_clk),
        .rst     (rst),
        .req     (req),
        .rdData  (rdData),
        .addrOk  (addrOk),
        .pready  (pready),
        .pslverr (pslverr),
        .prdata  (prdata),
        .wrStb   (wrStb)
    );

    wdt_sync u_halt (
        .sys_clk (sys_clk),
        .rst     (rst),
        .asyncIn (debugHalt),
        .syncOut (haltSync)
    );

    // Address decode
    always_comb begin
        unique case (req.addr)
            OFF_RELOAD,
            OFF_VALUE,
            OFF_CTRL,
            OFF_ICLR,
            OFF_STAT,
            OFF_LOCK: addrOk = 1'b1;
            default:  addrOk = 1'b0;
        endcase
    end

    assign cfgWr  = wrStb && !locked;
    assign ldWr   = cfgWr && (req.addr == OFF_RELOAD);
    assign ctlWr  = cfgWr && (req.addr == OFF_CTRL);
    assign clrWr  = wrStb && (req.addr == OFF_ICLR);
    assign lockWr = wrStb && (req.addr == OFF_LOCK);

    assign rawInt  = (state == WDT_PEND) || (state == WDT_BITE);
    assign tick    = (state == WDT_RUN || state == WDT_PEND)
                     && !(stallEn && haltSync);
    assign timeout = tick && (count == COUNT_ZERO);

    // Reload register
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            reloadValue <= RELOAD_RST;
        end else if (ldWr) begin
            reloadValue <= req.wdata;
        end
    end

    // Down counter
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            count <= RELOAD_RST;
        end else if (ldWr) begin
            count <= req.wdata;
        end else if (clrWr && state != WDT_IDLE) begin
            count <= reloadValue;
        end else if (timeout) begin
            count <= reloadValue;
        end else if (tick) begin
            count <= count - COUNT_ONE;
        end
    end

    // Control bits; enable is write-one, cleared only by reset
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            ctrlEn             <= 1'b0;
            rstEn              <= 1'b0;
            stallEn            <= 1'b0;
            maskedStatusSelect <= 1'b0;
        end else if (ctlWr) begin
            ctrlEn             <= ctrlEn | req.wdata[CTL_EN];
            rstEn              <= req.wdata[CTL_RSTEN];
            stallEn            <= req.wdata[CTL_STALL];
            maskedStatusSelect <= req.wdata[CTL_MSEL];
        end
    end

    // Lock: key unlocks, any other value locks
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            locked <= 1'b0;
        end else if (lockWr) begin
            locked <= (req.wdata != UNLOCK_KEY);
        end
    end

    // Timeout state; set wins over a clear in the same cycle
    always_comb begin
        next_state = state;
        unique case (state)
            WDT_IDLE: begin
                if (ctlWr && req.wdata[CTL_EN]) begin
                    next_state = WDT_RUN;
                end
            end
            WDT_RUN: begin
                if (timeout) begin
                    next_state = WDT_PEND;
                end
            end
            WDT_PEND: begin
                if (timeout && rstEn) begin
                    next_state = WDT_BITE;
                end else if (clrWr && !timeout) begin
                    next_state = WDT_RUN;
                end
            end
            WDT_BITE: begin
                next_state = WDT_BITE;
            end
        endcase
    end

    assign next_raw = (next_state == WDT_PEND) || (next_state == WDT_BITE);

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            state <= WDT_IDLE;
        end else begin
            state <= next_state;
        end
    end

    // Interrupt and reset outputs, registered
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            irq      <= 1'b0;
            sysReset <= 1'b0;
        end else begin
            irq      <= next_raw && (ctrlEn || ctlWr);
            sysReset <= (next_state == WDT_BITE);
        end
    end

    // Read mux
    always_comb begin
        rdData = COUNT_ZERO;
        unique case (req.addr)
            OFF_RELOAD: rdData = reloadValue;
            OFF_VALUE:  rdData = count;
            OFF_CTRL: begin
                rdData[CTL_EN]    = ctrlEn;
                rdData[CTL_RSTEN] = rstEn;
                rdData[CTL_STALL] = stallEn;
                rdData[CTL_MSEL]  = maskedStatusSelect;
            end
            OFF_STAT: begin
                rdData[STAT_INT] = maskedStatusSelect ?
                                   (rawInt && ctrlEn) : rawInt;
            end
            OFF_LOCK:   rdData[LOCK_BIT] = locked;
            default:    rdData = COUNT_ZERO;
        endcase
    end

    // Checks
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);

    sequence s_pend_zero;
        state == WDT_PEND && timeout;
    endsequence

    sequence s_run_zero;
        state == WDT_RUN && timeout;
    endsequence

    sequence s_quiet;
        !ldWr && !clrWr;
    endsequence

    sequence s_rd_setup;
        req.sel && !req.enable && !req.write;
    endsequence

    down_count_a: assert property (
        tick && count != COUNT_ZERO ##0 s_quiet
        |=> count == $past(count) - COUNT_ONE)
        else $error("counter did not step down by one");

    first_irq_a: assert property (
        s_run_zero |=> state == WDT_PEND && irq)
        else $error("first timeout did not raise interrupt");

    run_en_a: assert property (
        state != WDT_IDLE |-> ctrlEn)
        else $error("running without interrupt enabled");

    reload_zero_a: assert property (
        timeout ##0 !ldWr |=> count == $past(reloadValue))
        else $error("no reload after timeout");

    bite_a: assert property (
        s_pend_zero ##0 rstEn |=> sysReset [*2])
        else $error("second timeout did not reset");

    no_bite_a: assert property (
        s_pend_zero ##0 !rstEn && !sysReset |=> !sysReset)
        else $error("reset without reset enable");

    clear_reload_a: assert property (
        clrWr && state != WDT_IDLE && !ldWr |=> count == $past(reloadValue))
        else $error("clear did not reload counter");

    load_now_a: assert property (
        ldWr |=> count == $past(req.wdata) && reloadValue == count)
        else $error("reload write not loaded");

    lock_hold_a: assert property (
        wrStb && locked && req.addr == OFF_CTRL
        |=> $stable(rstEn) && $stable(stallEn) && $stable(ctrlEn))
        else $error("locked write changed control");

    lock_read_a: assert property (
        psel && !penable && !pwrite && paddr == OFF_LOCK
        |=> prdata[LOCK_BIT] == $past(locked))
        else $error("lock state read wrong");

    irq_clear_a: assert property (
        state == WDT_PEND && clrWr && !timeout |=> !irq && !rawInt)
        else $error("clear did not drop interrupt");

    stall_a: assert property (
        stallEn && haltSync ##0 s_quiet |=> $stable(count))
        else $error("counter moved during debug halt");

    reload_read_a: assert property (
        s_rd_setup ##0 req.addr == OFF_RELOAD |=> prdata == $past(reloadValue))
        else $error("reload read returned wrong value");

    value_read_a: assert property (
        s_rd_setup ##0 req.addr == OFF_VALUE |=> prdata == $past(count))
        else $error("counter read returned wrong value");

    stat_raw_a: assert property (
        s_rd_setup ##0 req.addr == OFF_STAT && !maskedStatusSelect
        |=> prdata[STAT_INT] == $past(rawInt))
        else $error("raw status read wrong");

    bite_hold_a: assert property (
        sysReset |=> sysReset)
        else $error("system reset dropped before reset");

    unlock_a: assert property (
        lockWr && req.wdata == UNLOCK_KEY |=> !locked)
        else $error("unlock key did not unlock");

    lock_set_a: assert property (
        lockWr && req.wdata != UNLOCK_KEY |=> locked)
        else $error("lock write did not lock");

    idle_hold_a: assert property (
        state == WDT_IDLE && !ldWr |=> $stable(count) && !irq)
        else $error("idle counter moved or interrupt raised");

    en_locked_a: assert property (
        state == WDT_IDLE && locked |=> state == WDT_IDLE)
        else $error("locked enable started counter");
endmodule

// File: verification/two_stage_watchdog_timer_tb.sv
// Self-checking testbench for the two-stage watchdog over APB.
`timescale 1ns/100ps
module two_stage_watchdog_timer_tb
    import wdt_pkg::*;
;
    localparam logic [31:0] EN    = 32'h1 << CTL_EN;
    localparam logic [31:0] RSTEN = 32'h1 << CTL_RSTEN;
    localparam logic [31:0] STALL = 32'h1 << CTL_STALL;
    localparam logic [31:0] MSEL  = 32'h1 << CTL_MSEL;

    logic               sys_clk     = 1'b0;
    logic               rst         = 1'b1;
    logic               psel        = 1'b0;
    logic               penable     = 1'b0;
    logic               pwrite      = 1'b0;
    logic [WDT_AW-1:0]  paddr       = '0;
    logic [31:0]        pwdata      = '0;
    logic               debugHalt   = 1'b0;
    logic               pready;
    logic               pslverr;
    logic [31:0]        prdata;
    logic               irq;
    logic               sysReset;
    logic [31:0]        rdat;
    logic [31:0]        v1;
    logic               rerr;
    int                 miscompares = 0;
    int                 checkCount  = 0;

    wdt_top u_dut (
        .sys_clk   (sys_clk),
        .rst       (rst),
        .psel      (psel),
        .penable   (penable),
        .pwrite    (pwrite),
        .paddr     (paddr),
        .pwdata    (pwdata),
        .debugHalt (debugHalt),
        .pready    (pready),
        .pslverr   (pslverr),
        .prdata    (prdata),
        .irq       (irq),
        .sysReset  (sysReset)
    );

    always #2.5 sys_clk = ~sys_clk;

    task automatic finalReport();
        if (miscompares == 0 && checkCount > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checkCount++;
        if (seen !== exp) begin
            miscompares++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic resetDut();
        rst <= 1'b1;
        repeat (12) @(posedge sys_clk);
        rst <= 1'b0;
    endtask

    // One APB transfer, then one idle cycle
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge sys_clk);
        penable <= 1'b1;
        do begin
            @(posedge sys_clk);
        end while (pready !== 1'b1);
        rdat = prdata;
        rerr = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge sys_clk);
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        xfer(1'b1, a, d);
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        xfer(1'b0, a, 32'h0);
        check(rdat, exp);
    endtask

    task automatic rng(input logic [31:0] lo, input logic [31:0] hi);
        xfer(1'b0, OFF_VALUE, 32'h0);
        check({31'b0, (rdat >= lo && rdat <= hi)}, 32'h1);
    endtask

    // Sel 0 watches irq, 1 watches sysReset
    task automatic expectPin(input int sel, input logic exp, input int lim);
        int n;
        n = 0;
        @(negedge sys_clk);
        while (((sel == 0) ? irq : sysReset) !== exp && n < lim) begin
            @(negedge sys_clk);
            n++;
        end
        check({31'b0, ((sel == 0) ? irq : sysReset)}, {31'b0, exp});
        @(posedge sys_clk);
    endtask

    initial begin
        #(5 * 20000);
        miscompares++;
        finalReport();
    end

    initial begin
        resetDut();
        expectPin(0, 1'b0, 0);
        expectPin(1, 1'b0, 0);
        rd(OFF_RELOAD, RELOAD_RST);
        rd(OFF_CTRL, 32'h0);
        rd(OFF_LOCK, 32'h0);
        rd(OFF_STAT, 32'h0);
        rd(8'h40, 32'h0);
        check({31'b0, rerr}, 32'h1);
        wr(OFF_RELOAD, 32'h20);
        rd(OFF_RELOAD, 32'h20);
        rd(OFF_VALUE, 32'h20);
        // Locked configuration ignores writes
        wr(OFF_LOCK, 32'h0);
        rd(OFF_LOCK, 32'h1);
        wr(OFF_CTRL, EN);
        rd(OFF_CTRL, 32'h0);
        wr(OFF_RELOAD, 32'h5);
        rd(OFF_RELOAD, 32'h20);
        wr(OFF_LOCK, UNLOCK_KEY);
        rd(OFF_LOCK, 32'h0);
        // First timeout
        wr(OFF_CTRL, EN);
        expectPin(0, 1'b1, 60);
        rd(OFF_STAT, 32'h1);
        wr(OFF_CTRL, EN | MSEL);
        rd(OFF_STAT, 32'h1);
        wr(OFF_ICLR, 32'h0);
        expectPin(0, 1'b0, 0);
        wr(OFF_RELOAD, 32'h1000);
        rng(32'hff0, 32'h1000);
        // Count keeps running between reads
        xfer(1'b0, OFF_VALUE, 32'h0);
        v1 = rdat;
        xfer(1'b0, OFF_VALUE, 32'h0);
        check(v1 - rdat, 32'h3);
        wr(OFF_CTRL, EN | STALL);
        debugHalt <= 1'b1;
        repeat (4) @(posedge sys_clk);
        xfer(1'b0, OFF_VALUE, 32'h0);
        v1 = rdat;
        rd(OFF_VALUE, v1);
        debugHalt <= 1'b0;
        repeat (4) @(posedge sys_clk);
        xfer(1'b0, OFF_VALUE, 32'h0);
        v1 = rdat;
        xfer(1'b0, OFF_VALUE, 32'h0);
        check(v1 - rdat, 32'h3);
        // Zero reload, repeated timeouts without reset enable
        wr(OFF_RELOAD, 32'h0);
        expectPin(0, 1'b1, 4);
        repeat (20) @(posedge sys_clk);
        expectPin(1, 1'b0, 0);
        // Second timeout with reset enabled
        wr(OFF_RELOAD, 32'h6);
        wr(OFF_ICLR, 32'h0);
        wr(OFF_CTRL, EN | RSTEN);
        expectPin(0, 1'b1, 20);
        rng(32'h0, 32'h6);
        expectPin(1, 1'b1, 20);
        resetDut();
        expectPin(1, 1'b0, 0);
        rd(OFF_RELOAD, RELOAD_RST);
        finalReport();
    end
endmodule
